// >>> rtl/lcdhi_host_port.sv
`timescale 1ns/1ps
module lcdhi_host_port
    import lcdhi_pkg::*;
#(
    parameter int DATA_W = 8
)
(
    input  wire logic                CLOCK,
    input  wire logic                SYS_RST,
    input  wire logic [WB_ADR_W-1:0] WB_ADR_I,
    input  wire logic [WB_DAT_W-1:0] WB_DAT_I,
    output wire logic [WB_DAT_W-1:0] WB_DAT_O,
    input  wire logic                WB_WE_I,
    input  wire logic [3:0]          WB_SEL_I,
    input  wire logic                WB_STB_I,
    input  wire logic                WB_CYC_I,
    output wire logic                WB_ACK_O,
    output wire logic                IRQ,
    input  wire logic                PAR_SER_SELECT,
    input  wire logic                BUS_STYLE_SELECT,
    input  wire logic                CHIP_SELECT_LOW_N,
    input  wire logic                CHIP_SELECT_HIGH,
    input  wire logic                DATA_COMMAND_SELECT,
    input  wire logic                RD_ENABLE,
    input  wire logic                WR_DIRECTION,
    input  wire logic [DATA_W-1:0]   DATA_IN,
    output wire logic [DATA_W-1:0]   DATA_OUT,
    output wire logic                DATA_OE,
    input  wire logic                BUSY_IN,
    input  wire logic [DATA_W-1:0]   RAM_RD_DATA,
    output wire logic                RAM_RD_STB,
    output wire logic [DATA_W-1:0]   CMD_BYTE,
    output wire logic                CMD_STB,
    output wire logic [DATA_W-1:0]   DATA_BYTE,
    output wire logic                DATA_STB
);
    // the pin decode is written for one byte lane only
    if (DATA_W != BYTE_W)
    begin : g_width_check
        $error("lcdhi_host_port: DATA_W must equal BYTE_W");
    end

    // whole state of the block
    typedef struct packed
    {
        logic [7:0]  shift;     // serial shift register
        logic [2:0]  cnt;       // serial bits taken so far
        logic [7:0]  holder;    // bus holder between host and ram
        logic [7:0]  dout;      // byte driven on the host bus
        logic        oe;        // host bus drive enable
        logic [7:0]  cmd;       // last command byte
        logic        cmd_stb;   // command pulse
        logic        data_stb;  // display data pulse
        logic        rd_stb;    // ram read advance pulse
        logic        ctl_busy;  // software forced busy
        logic [3:0]  stat;      // sticky events
        logic [3:0]  mask;      // event enables
        logic        ack;       // bus acknowledge
        logic [31:0] rdat;      // bus read data
    } lcdhi_core_t;

    lcdhi_core_t r_reg;    // registered state
    lcdhi_core_t r_next;   // next state

    lcdhi_pin_if pins ();  // synchronised pins

    lcdhi_pins_t pins_raw; // raw pin bundle
    assign pins_raw = '{ps: PAR_SER_SELECT, bstyle: BUS_STYLE_SELECT,
                        csl_n: CHIP_SELECT_LOW_N, csh: CHIP_SELECT_HIGH,
                        dcsel: DATA_COMMAND_SELECT, rd: RD_ENABLE,
                        wr: WR_DIRECTION, d: DATA_IN};

    // every pin passes two flops before use
    lcdhi_sync u_sync
    (
        .clk      (CLOCK),
        .rst      (SYS_RST),
        .pins_raw (pins_raw),
        .pins     (pins)
    );

    // decoded pin events
    logic       sel;        // chip selected now
    logic       ser;        // serial mode now
    logic       busy;       // internal processing
    logic       rd_start;   // parallel read strobe begins
    logic       rd_end;     // parallel read strobe ends
    logic       wr_end;     // parallel write strobe ends
    logic       scl_rise;   // serial clock rising edge
    logic [7:0] ser_byte;   // byte completed by this edge
    logic       bus_req;    // wishbone request pending
    logic       bus_wr;     // wishbone write taken now
    logic [3:0] ev;         // events of this cycle

    assign sel      = pin_selected(pins.cur);
    assign ser      = !pins.cur.ps;
    assign busy     = BUSY_IN || r_reg.ctl_busy;
    // strobe style follows bus_style_select through rd_active/wr_active
    assign rd_start = rd_active(pins.cur) && !rd_active(pins.prev);
    assign rd_end   = !rd_active(pins.cur) && rd_active(pins.prev);
    assign wr_end   = wr_active(pins.prev) && !wr_active(pins.cur);
    assign scl_rise = ser && sel && pins.cur.d[SCL_POS] && !pins.prev.d[SCL_POS];
    assign ser_byte = {r_reg.shift[6:0], pins.prev.d[SI_POS]};
    assign bus_req  = WB_CYC_I && WB_STB_I && !r_reg.ack;
    // a write lands only at the edge where the master sees ack high
    assign bus_wr   = WB_CYC_I && WB_STB_I && r_reg.ack && WB_WE_I && WB_SEL_I[0];

    // read data multiplexer for the register bus
    function automatic logic [31:0] reg_read(input lcdhi_core_t s, input logic [4:0] adr,
                                             input logic sl, input logic sr, input logic bz);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (adr)
            ADR_CTRL: v[CTRL_BUSY] = s.ctl_busy;
            ADR_STAT: v[EV_W-1:0] = s.stat;
            ADR_MASK: v[EV_W-1:0] = s.mask;
            ADR_LCMD: v[BYTE_W-1:0] = s.cmd;
            ADR_INFO:
            begin
                v[INFO_SEL]            = sl;
                v[INFO_SER]            = sr;
                v[INFO_BUSY]           = bz;
                v[INFO_CNT+2:INFO_CNT] = s.cnt;
            end
            default: v = 32'h0000_0000;   // unmapped reads as zero
        endcase
        return v;
    endfunction

    // next state of the whole block
    always_comb
    begin
        r_next          = r_reg;
        ev              = EV_RST;
        r_next.cmd_stb  = 1'b0;
        r_next.data_stb = 1'b0;
        r_next.rd_stb   = 1'b0;

        // serial receiver; only while selected in serial mode
        if (!(ser && sel))
        begin
            r_next.shift = BYTE_RST;
            r_next.cnt   = CNT_RST;
        end
        else if (scl_rise)
        begin
            r_next.shift = ser_byte;
            r_next.cnt   = r_reg.cnt + 3'h1;
            if (r_reg.cnt == CNT_LAST)
            begin
                r_next.shift = BYTE_RST;
                if (busy)
                    ev[EV_REFUSE] = 1'b1;
                else if (!pins.prev.dcsel)
                begin
                    r_next.cmd     = ser_byte;
                    r_next.cmd_stb = 1'b1;
                    ev[EV_CMD]     = 1'b1;
                end
                else
                begin
                    r_next.holder   = ser_byte;
                    r_next.data_stb = 1'b1;
                    ev[EV_WDATA]    = 1'b1;
                end
            end
        end

        // parallel write: data and select taken just before strobe end
        if (wr_end)
        begin
            if (busy)
                ev[EV_REFUSE] = 1'b1;
            else if (!pins.prev.dcsel)
            begin
                r_next.cmd     = pins.prev.d;
                r_next.cmd_stb = 1'b1;
                ev[EV_CMD]     = 1'b1;
            end
            else
            begin
                r_next.holder   = pins.prev.d;
                r_next.data_stb = 1'b1;
                ev[EV_WDATA]    = 1'b1;
            end
        end

        // parallel read start: status or holder goes on the bus
        if (rd_start)
        begin
            if (!pins.cur.dcsel)
            begin
                r_next.dout           = BYTE_RST;
                r_next.dout[BUSY_POS] = busy;
            end
            else if (busy)
            begin
                r_next.dout   = BYTE_RST;
                ev[EV_REFUSE] = 1'b1;
            end
            else
                r_next.dout = r_reg.holder;
        end

        // data read end: holder refilled, ram address moves on
        if (rd_end && pins.prev.dcsel && !busy)
        begin
            r_next.holder = RAM_RD_DATA;
            r_next.rd_stb = 1'b1;
            ev[EV_RDATA]  = 1'b1;
        end

        // drive only during a selected parallel read
        r_next.oe = rd_active(pins.cur);

        // register bus slave, one wait state
        r_next.ack  = bus_req;
        r_next.rdat = reg_read(r_reg, WB_ADR_I, sel, ser, busy);
        if (bus_wr && WB_ADR_I == ADR_CTRL)
            r_next.ctl_busy = WB_DAT_I[CTRL_BUSY];
        if (bus_wr && WB_ADR_I == ADR_MASK)
            r_next.mask = WB_DAT_I[EV_W-1:0];

        // sticky events; a new event beats a clear in the same cycle
        if (bus_wr && WB_ADR_I == ADR_STAT)
            r_next.stat = r_reg.stat & ~WB_DAT_I[EV_W-1:0];
        r_next.stat = r_next.stat | ev;
    end

    // single state register
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            r_reg          <= '0;
            r_reg.shift    <= BYTE_RST;
            r_reg.cnt      <= CNT_RST;
            r_reg.holder   <= BYTE_RST;
            r_reg.stat     <= EV_RST;
            r_reg.mask     <= EV_RST;
        end
        else
            r_reg <= r_next;
    end

    // outputs; all but the interrupt come straight from flops
    assign WB_ACK_O   = r_reg.ack;
    assign WB_DAT_O   = r_reg.rdat;
    assign IRQ        = |(r_reg.stat & r_reg.mask);
    assign DATA_OUT   = r_reg.dout;
    assign DATA_OE    = r_reg.oe;
    assign RAM_RD_STB = r_reg.rd_stb;
    assign CMD_BYTE   = r_reg.cmd;
    assign CMD_STB    = r_reg.cmd_stb;
    assign DATA_BYTE  = r_reg.holder;
    assign DATA_STB   = r_reg.data_stb;

    // serial mode never drives the host bus
    AST_SER_NO_DRIVE: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        ser && $past(ser) |-> !DATA_OE)
        else $error("bus driven in serial mode");

    // drive enable only follows a selected cycle
    AST_OE_NEEDS_SEL: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        $rose(DATA_OE) |-> $past(sel))
        else $error("bus driven while not selected");

    // status read carries busy in the top bit
    AST_STATUS_BUSY: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        rd_start && !pins.cur.dcsel |=> DATA_OUT == {$past(busy), 7'h00} && DATA_OE)
        else $error("status byte wrong");

    // data read presents the old holder, then refills it
    AST_HOLDER_READ: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        rd_start && pins.cur.dcsel && !busy |=> DATA_OUT == $past(r_reg.holder))
        else $error("read did not show holder");

    // accepted data write lands in holder with one pulse
    AST_WRITE_HOLDER: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        wr_end && pins.prev.dcsel && !busy
            |=> DATA_STB && DATA_BYTE == $past(pins.prev.d) ##1 !DATA_STB)
        else $error("data write not stored");

    // busy refuses parallel writes
    AST_BUSY_BLOCK: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        wr_end && busy && !scl_rise |=> !CMD_STB && !DATA_STB)
        else $error("write taken while busy");

    // deselect clears the serial receiver
    AST_SER_CLEAR: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        !sel |=> r_reg.cnt == CNT_RST && r_reg.shift == BYTE_RST)
        else $error("serial state kept while deselected");

    // eighth serial edge with select low gives a command byte
    AST_SER_CMD: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        scl_rise && r_reg.cnt == CNT_LAST && !pins.prev.dcsel && !busy
            |=> CMD_STB && CMD_BYTE == $past(ser_byte))
        else $error("serial command byte lost");

    // eighth serial edge with select high gives a data byte
    AST_SER_DATA: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        scl_rise && r_reg.cnt == CNT_LAST && pins.prev.dcsel && !busy
            |=> DATA_STB && DATA_BYTE == $past(ser_byte))
        else $error("serial data byte lost");

    // data pulse lasts exactly one cycle
    AST_DATA_PULSE: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        DATA_STB |=> !DATA_STB)
        else $error("data pulse too long");

    // command pulse lasts exactly one cycle
    AST_CMD_PULSE: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        CMD_STB |=> !CMD_STB)
        else $error("command pulse too long");

    // bus slave answers one cycle after the request
    AST_WB_ACK: assert property (
        @(posedge CLOCK) disable iff (SYS_RST)
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("wishbone ack late");
endmodule

// >>> rtl/lcdhi_pkg.sv
package lcdhi_pkg;

    // sampled host pins, one field per pin
    typedef struct packed
    {
        logic       ps;     // parallel/serial strap, high = parallel
        logic       bstyle; // bus_style_select, high = 6800 style
        logic       csl_n;  // chip_select_low, active low
        logic       csh;    // chip_select_high, active high
        logic       dcsel;  // data_command_select, high = display data
        logic       rd;     // read strobe (8080) or enable (6800)
        logic       wr;     // write strobe (8080) or direction (6800)
        logic [7:0] d;      // data bus; d[6] serial clock, d[7] serial data
    } lcdhi_pins_t;

    localparam int          BYTE_W       = 8;
    localparam int          WB_ADR_W     = 5;
    localparam int          WB_DAT_W     = 32;
    localparam int          EV_W         = 4;
    localparam int          SCL_POS      = 6;
    localparam int          SI_POS       = 7;
    localparam int          BUSY_POS     = 7;

    // register byte addresses
    localparam logic [4:0]  ADR_CTRL     = 5'h00;
    localparam logic [4:0]  ADR_STAT     = 5'h04;
    localparam logic [4:0]  ADR_MASK     = 5'h08;
    localparam logic [4:0]  ADR_LCMD     = 5'h0c;
    localparam logic [4:0]  ADR_INFO     = 5'h10;

    // event bits of status and mask
    localparam int          EV_CMD       = 0;
    localparam int          EV_WDATA     = 1;
    localparam int          EV_RDATA     = 2;
    localparam int          EV_REFUSE    = 3;

    // control and info fields
    localparam int          CTRL_BUSY    = 0;
    localparam int          INFO_SEL     = 0;
    localparam int          INFO_SER     = 1;
    localparam int          INFO_BUSY    = 2;
    localparam int          INFO_CNT     = 4;

    // reset values and the last serial count
    localparam logic [2:0]  CNT_RST      = 3'h0;
    localparam logic [2:0]  CNT_LAST     = 3'h7;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [3:0]  EV_RST       = 4'h0;
    localparam lcdhi_pins_t PINS_RST     = '{ps: 1'b1, bstyle: 1'b0, csl_n: 1'b1, csh: 1'b0,
                                             dcsel: 1'b0, rd: 1'b1, wr: 1'b1, d: 8'h00};

    // chip counts as selected only for low/high select pair
    function automatic logic pin_selected(input lcdhi_pins_t p);
        return !p.csl_n && p.csh;
    endfunction

    // parallel read strobe active and selected
    function automatic logic rd_active(input lcdhi_pins_t p);
        return p.ps && pin_selected(p) && (p.bstyle ? (p.rd && p.wr) : !p.rd);
    endfunction

    // parallel write strobe active and selected
    function automatic logic wr_active(input lcdhi_pins_t p);
        return p.ps && pin_selected(p) && (p.bstyle ? (p.rd && !p.wr) : !p.wr);
    endfunction

endpackage

// >>> rtl/lcdhi_pin_if.sv
`timescale 1ns/1ps
interface lcdhi_pin_if;
    import lcdhi_pkg::*;
    lcdhi_pins_t cur;   // synchronised pin levels
    lcdhi_pins_t prev;  // same, one cycle older, for edge finding
    modport src (output cur, output prev);
    modport dst (input cur, input prev);
endinterface

// >>> rtl/lcdhi_sync.sv
`timescale 1ns/1ps
module lcdhi_sync
    import lcdhi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire lcdhi_pins_t pins_raw,
    lcdhi_pin_if.src         pins
);
    // two flops against metastability, a third for edges
    typedef struct packed
    {
        lcdhi_pins_t s1;
        lcdhi_pins_t s2;
        lcdhi_pins_t s3;
    } lcdhi_sync_t;

    lcdhi_sync_t sync_reg;    // current state
    lcdhi_sync_t sync_next;   // next state

    // first stage feeds only the second stage
    always_comb
    begin
        sync_next    = sync_reg;
        sync_next.s1 = pins_raw;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
    end

    // idle pins after reset, so no false strobe edges
    always_ff @(posedge clk)
    begin
        if (rst)
            sync_reg <= '{s1: PINS_RST, s2: PINS_RST, s3: PINS_RST};
        else
            sync_reg <= sync_next;
    end

    assign pins.cur  = sync_reg.s2;
    assign pins.prev = sync_reg.s3;
endmodule

// >>> verification/lcdhi_host_model.sv
`timescale 1ns/1ps
module lcdhi_host_model
    import lcdhi_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] bus_in,  // resolved data bus
    output logic            ps,
    output logic            bstyle,
    output logic            csl_n,
    output logic            csh,
    output logic            dcsel,
    output logic            rd,
    output logic            wr,
    output logic [7:0]      d        // host side of the data bus
);
    // idle host: parallel strap, deselected, 8080 strobes high
    initial
    begin
        {ps, bstyle, csl_n, csh, dcsel, rd, wr} = 7'b1010011;
        d = 8'h5a;
    end

    // one parallel cycle; sel is {csl_n, csh}; phases long enough to skip busy polls
    task automatic par_xfer(input logic sty, input logic is_rd, input logic dc,
                            input logic [1:0] sel, input logic [7:0] wd,
                            output logic [7:0] rdat);
        @(posedge clk);
        ps  <= 1'b1;
        bstyle <= sty;
        rd  <= !sty;                 // strobe inactive for the chosen style
        wr  <= sty ? is_rd : 1'b1;
        dcsel <= dc;
        d   <= is_rd ? ~d : wd;      // released bus shows inverse, never the old byte
        repeat (4) @(posedge clk);
        {csl_n, csh} <= sel;
        repeat (6) @(posedge clk);
        if (sty)
            rd <= 1'b1;              // enable high opens the access
        else if (is_rd)
            rd <= 1'b0;
        else
            wr <= 1'b0;
        repeat (8) @(posedge clk);
        rdat = bus_in;
        rd <= !sty;                  // strobe end; data still held
        wr <= sty ? is_rd : 1'b1;
        repeat (6) @(posedge clk);
        {csl_n, csh} <= 2'b10;
        d <= ~d;
        repeat (6) @(posedge clk);
    endtask

    // serial frame of nb bits, msb first; link clock stands low outside it
    task automatic ser_xfer(input logic dc, input logic [1:0] sel, input logic [7:0] b,
                            input int nb);
        logic [7:0] lv;   // link lines as driven
        lv = 8'h00;
        @(posedge clk);
        {ps, rd, wr, dcsel} <= {1'b0, 1'b1, 1'b1, dc};
        d <= lv;
        repeat (4) @(posedge clk);
        {csl_n, csh} <= sel;
        repeat (4) @(posedge clk);
        // 200 ns link clock: four system clocks low, four high
        for (int i = 7; i > 7 - nb; i--)
        begin
            lv[SI_POS]  = b[i];
            lv[SCL_POS] = 1'b0;
            d <= lv;
            repeat (4) @(posedge clk);
            lv[SCL_POS] = 1'b1;
            d <= lv;
            repeat (4) @(posedge clk);
        end
        // clock back low, data flipped so no stale bit lingers
        lv[SCL_POS] = 1'b0;
        lv[SI_POS]  = ~lv[SI_POS];
        d <= lv;
        repeat (4) @(posedge clk);
        {csl_n, csh} <= 2'b10;
        repeat (6) @(posedge clk);
    endtask
endmodule

// >>> verification/lcd_controller_host_interface_tb.sv
`timescale 1ns/1ps
module lcd_controller_host_interface_tb;
    import lcdhi_pkg::*;

    logic        clk = 1'b0;       // system clock
    logic        rst = 1'b1;       // synchronous reset
    logic [4:0]  wb_adr = 5'h00;
    logic [31:0] wb_dw = 32'h0;
    logic [31:0] wb_dr;
    logic        wb_we = 1'b0;
    logic        wb_cs = 1'b0;     // cyc and stb move together
    logic [3:0]  wb_sel = 4'hf;
    logic [3:0]  sel_nx = 4'hf;    // byte enables for the next request
    logic        wb_ack, irq, oe, ram_stb, cmd_stb, dat_stb;
    logic        busy = 1'b0;      // core busy input
    logic [7:0]  ram_q = 8'h00;    // ram byte at current address
    logic        ps, bstyle, csl_n, csh, dcsel, rd, wr;
    logic [7:0]  host_d, bus, dout, cmd_b, dat_b, last_cmd, last_dat;
    logic        oe_seen = 1'b0;   // sticky: bus ever driven
    int          errors = 0;
    int          n_checks = 0;
    int          n_cmd = 0;
    int          n_dat = 0;
    int          n_ram = 0;

    // wire level seen by both parties
    assign bus = oe ? dout : host_d;

    // free running system clock
    always #12.5 clk = ~clk;

    lcdhi_host_port DUT (
        .CLOCK(clk), .SYS_RST(rst), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dw),
        .WB_DAT_O(wb_dr), .WB_WE_I(wb_we), .WB_SEL_I(wb_sel), .WB_STB_I(wb_cs),
        .WB_CYC_I(wb_cs), .WB_ACK_O(wb_ack), .IRQ(irq), .PAR_SER_SELECT(ps),
        .BUS_STYLE_SELECT(bstyle), .CHIP_SELECT_LOW_N(csl_n), .CHIP_SELECT_HIGH(csh),
        .DATA_COMMAND_SELECT(dcsel), .RD_ENABLE(rd), .WR_DIRECTION(wr), .DATA_IN(bus),
        .DATA_OUT(dout), .DATA_OE(oe), .BUSY_IN(busy), .RAM_RD_DATA(ram_q),
        .RAM_RD_STB(ram_stb), .CMD_BYTE(cmd_b), .CMD_STB(cmd_stb), .DATA_BYTE(dat_b),
        .DATA_STB(dat_stb));

    lcdhi_host_model host (
        .clk(clk), .bus_in(bus), .ps(ps), .bstyle(bstyle), .csl_n(csl_n), .csh(csh),
        .dcsel(dcsel), .rd(rd), .wr(wr), .d(host_d));

    // pulses counted at the edge that samples them
    always @(posedge clk)
    begin
        n_cmd += (cmd_stb === 1'b1);
        n_dat += (dat_stb === 1'b1);
        n_ram += (ram_stb === 1'b1);
        if (cmd_stb === 1'b1) last_cmd = cmd_b;
        if (dat_stb === 1'b1) last_dat = dat_b;
        if (oe !== 1'b0) oe_seen = 1'b1;
    end

    // status event expected from one accepted write
    function automatic logic [3:0] exp_ev(input logic dc);
        return dc ? 4'h2 : 4'h1;
    endfunction

    task automatic print_verdict();
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL %0t: %s", $time, m);
        end
    endtask

    // classic single cycle; waits for ack, then idles a cycle
    task automatic wb(input logic we, input logic [4:0] adr, input logic [31:0] dw,
                      output logic [31:0] dr);
        int n;
        n = 0;
        @(posedge clk);
        {wb_cs, wb_we, wb_adr, wb_dw, wb_sel} <= {1'b1, we, adr, dw, sel_nx};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        dr = wb_dr;
        if (n >= 50) chk(0, 1, "no acknowledge");
        wb_cs <= 1'b0;
        @(posedge clk);
    endtask

    // host write; mode 0 8080, 1 6800, 2 serial; ok says whether a pulse is due
    task automatic host_wr(input int mode, input logic dc, input logic [1:0] sel,
                           input logic [7:0] b, input int nb, input logic ok);
        int c0, d0;
        logic [7:0] r;
        c0 = n_cmd;
        d0 = n_dat;
        if (mode == 2)
            host.ser_xfer(dc, sel, b, nb);
        else
            host.par_xfer(mode[0], 1'b0, dc, sel, b, r);
        repeat (8) @(posedge clk);
        chk(n_cmd - c0, (ok && !dc) ? 1 : 0, "command pulse count");
        chk(n_dat - d0, (ok && dc) ? 1 : 0, "data pulse count");
        if (ok) chk(dc ? last_dat : last_cmd, b, "forwarded byte");
    endtask

    task automatic host_rd(input int mode, input logic dc, input logic [1:0] sel,
                           output logic [7:0] r);
        host.par_xfer(mode[0], 1'b1, dc, sel, 8'h00, r);
        repeat (4) @(posedge clk);
    endtask

    // watchdog, far beyond the length of the sequence
    initial
    begin
        #2000000;
        errors++;
        $display("FAIL %0t: watchdog expired", $time);
        print_verdict();
    end

    // main sequence
    initial
    begin
        logic [7:0] b, r, w, r1;
        logic [31:0] v;
        logic [3:0] ev;
        logic [4:0] adrs [6];
        logic [1:0] bad [3];
        adrs = '{ADR_CTRL, ADR_STAT, ADR_MASK, ADR_LCMD, ADR_INFO, 5'h14};
        bad = '{2'b11, 2'b00, 2'b10};
        ev = 4'h0;
        void'($urandom(32'hcc2cacec));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(irq, 0, "irq after reset");
        wb(1, ADR_LCMD, 32'h5a, v);
        foreach (adrs[i])
        begin
            wb(0, adrs[i], 0, v);
            chk(v, 0, "reset value or unmapped read");
        end
        // random writes across both styles and both kinds
        for (int i = 0; i < 8; i++)
        begin
            b = 8'($urandom);
            host_wr(i % 2, i[1], 2'b01, b, 8, 1'b1);
            ev |= exp_ev(i[1]);
        end
        wb(0, ADR_STAT, 0, v);
        chk(v[3:0], ev, "status after writes");
        // interrupt raised, masked, cleared
        wb(1, ADR_STAT, 32'hf, v);
        b = 8'($urandom);
        host_wr(1, 0, 2'b01, b, 8, 1'b1);
        wb(0, ADR_LCMD, 0, v);
        chk(v[7:0], b, "last command register");
        chk(irq, 0, "masked interrupt");
        wb(1, ADR_MASK, 32'h1, v);
        chk(irq, 1, "interrupt raised");
        sel_nx = 4'he;
        wb(1, ADR_MASK, 32'h0, v);
        chk(irq, 1, "write without byte lane ignored");
        sel_nx = 4'hf;
        wb(1, ADR_STAT, 32'h1, v);
        chk(irq, 0, "interrupt cleared");
        // busy refuses all but status reads
        busy <= 1'b1;
        host_wr(0, 0, 2'b01, 8'h81, 8, 1'b0);
        host_rd(0, 0, 2'b01, r);
        chk(r[BUSY_POS], 1, "busy on status top bit");
        host_rd(1, 1, 2'b01, r);
        chk(r, 0, "refused data read");
        wb(0, ADR_STAT, 0, v);
        chk(v[EV_REFUSE], 1, "refusal event");
        busy <= 1'b0;
        wb(1, ADR_CTRL, 32'h1, v);
        host_rd(1, 0, 2'b01, r);
        chk(r[BUSY_POS], 1, "forced busy on status");
        wb(1, ADR_CTRL, 32'h0, v);
        host_rd(0, 0, 2'b01, r);
        chk(r[BUSY_POS], 0, "idle status top bit");
        // dummy read after a write returns the holder
        w = 8'($urandom);
        r1 = 8'($urandom);
        host_wr(0, 1, 2'b01, w, 8, 1'b1);
        ram_q <= r1;
        host_rd(0, 1, 2'b01, r);
        chk(r, w, "dummy read shows holder");
        ram_q <= ~r1;
        host_rd(1, 1, 2'b01, r);
        chk(r, r1, "second read shows ram");
        chk(n_ram, 2, "holder refills");
        // no access while deselected
        foreach (bad[i])
        begin
            oe_seen = 1'b0;
            host_wr(i % 2, 0, bad[i], 8'h3c, 8, 1'b0);
            host_rd(i % 2, 1, bad[i], r);
            chk(oe_seen, 0, "bus driven while deselected");
        end
        // serial: partial byte dropped, then whole bytes
        oe_seen = 1'b0;
        host_wr(2, 0, 2'b01, 8'ha5, 5, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            b = 8'($urandom);
            host_wr(2, i[0], 2'b01, b, 8, 1'b1);
        end
        host_wr(2, 1, 2'b00, 8'h0f, 8, 1'b0);
        wb(0, ADR_INFO, 0, v);
        chk(v[INFO_SER], 1, "serial mode flag");
        chk(oe_seen, 0, "bus driven in serial mode");
        print_verdict();
    end
endmodule
